/* core/crxf_rx_buffer_full_flags.sv */
// top: receive buffer full flags with register port and interrupt
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module crxf_rx_buffer_full_flags
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// receive path store event
	input wire logic i_store_valid,
	input wire logic [4:0] i_store_index,
	// register port
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	// flags and interrupt
	output logic [31:0] o_rx_buffer_full_flag,
	output logic o_irq
);
	// store path: same clock as the receive logic, so no synchroniser
	logic [31:0] set_vec;
	logic [15:0] set_low;
	logic [15:0] set_high;
	// flag banks as held inside the block
	logic [15:0] flags_low;
	logic [15:0] flags_high;
	// decoded write strobes
	logic wr_low;
	logic wr_high;
	logic wr_status;
	logic wr_mask;
	// interrupt status, mask and line
	logic stored_q;
	logic overrun_q;
	logic overrun_low;
	logic overrun_high;
	logic [1:0] irq_event;
	logic [1:0] irq_status;
	logic [1:0] irq_mask_q;
	logic irq_q;
	// read path and flag output copies
	logic [15:0] rd_mux;
	logic [15:0] rdata_q;
	logic [15:0] flags_low_q;
	logic [15:0] flags_high_q;

	// one-hot decode of the stored buffer index
	function automatic logic [31:0] decode_index(input logic [4:0] idx);
		logic [31:0] v;
		v = 32'h00000000;
		v[idx] = 1'h1;
		return v;
	endfunction

	// write strobe qualified by one register offset
	function automatic logic reg_hit(input logic strobe, input logic [3:0] addr, input logic [3:0] ofs);
		return strobe && (addr == ofs);
	endfunction

	// write-one-to-clear status bit; the event wins so no store goes unreported
	function automatic logic w1c_next(input logic cur, input logic wr, input logic clr, input logic evt);
		logic nxt;
		nxt = cur;
		if (wr && clr)
		begin
			nxt = 1'h0;
		end
		return nxt || evt;
	endfunction

	// set request vector, split per bank
	assign set_vec = i_store_valid ? decode_index(i_store_index) : 32'h00000000;
	assign set_low = set_vec[15:0];
	assign set_high = set_vec[31:16];

	// write strobes; unmapped offsets select nothing
	assign wr_low = reg_hit(i_wr, i_addr, crxf_pkg::OFS_RX_BUFFER_FULL_LOW);
	assign wr_high = reg_hit(i_wr, i_addr, crxf_pkg::OFS_RX_BUFFER_FULL_HIGH);
	assign wr_status = reg_hit(i_wr, i_addr, crxf_pkg::OFS_IRQ_STATUS);
	assign wr_mask = reg_hit(i_wr, i_addr, crxf_pkg::OFS_IRQ_MASK);

	// low bank: buffers 0..15
	crxf_flag_bank u_bank_low
	(
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_set(set_low),
		.i_clr_wr(wr_low),
		.i_clr_data(i_wdata),
		.o_flags(flags_low)
	);

	// high bank: buffers 16..31
	crxf_flag_bank u_bank_high
	(
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_set(set_high),
		.i_clr_wr(wr_high),
		.i_clr_data(i_wdata),
		.o_flags(flags_high)
	);

	// overrun: a store lands in a buffer whose flag is still up
	assign overrun_low = |(set_low & flags_low);
	assign overrun_high = |(set_high & flags_high);

	// status events: any store, and a store into a full buffer
	assign irq_event[crxf_pkg::IRQ_BIT_STORED] = i_store_valid;
	assign irq_event[crxf_pkg::IRQ_BIT_OVERRUN] = overrun_low || overrun_high;

	// store status bit, sticky until software writes a one
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			stored_q <= crxf_pkg::RST_IRQ[crxf_pkg::IRQ_BIT_STORED];
		end
		else
		begin
			stored_q <= w1c_next(stored_q, wr_status, i_wdata[crxf_pkg::IRQ_BIT_STORED],
				irq_event[crxf_pkg::IRQ_BIT_STORED]);
		end
	end

	// overrun status bit, cleared the same way as the store bit
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			overrun_q <= crxf_pkg::RST_IRQ[crxf_pkg::IRQ_BIT_OVERRUN];
		end
		else
		begin
			overrun_q <= w1c_next(overrun_q, wr_status, i_wdata[crxf_pkg::IRQ_BIT_OVERRUN],
				irq_event[crxf_pkg::IRQ_BIT_OVERRUN]);
		end
	end

	// status word as software sees it
	assign irq_status[crxf_pkg::IRQ_BIT_STORED] = stored_q;
	assign irq_status[crxf_pkg::IRQ_BIT_OVERRUN] = overrun_q;

	// interrupt mask, plain read/write
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			irq_mask_q <= crxf_pkg::RST_IRQ;
		end
		else if (wr_mask)
		begin
			irq_mask_q <= i_wdata[1:0];
		end
	end

	// level interrupt, registered so it lags status by one cycle
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			irq_q <= crxf_pkg::RST_IRQ_LINE;
		end
		else
		begin
			irq_q <= |(irq_status & irq_mask_q);
		end
	end

	// read mux; unmapped offsets read zero
	always_comb
	begin
		rd_mux = 16'h0000;
		unique case (i_addr)
			crxf_pkg::OFS_RX_BUFFER_FULL_LOW: rd_mux = flags_low;
			crxf_pkg::OFS_RX_BUFFER_FULL_HIGH: rd_mux = flags_high;
			crxf_pkg::OFS_IRQ_STATUS: rd_mux = {14'h0000, irq_status};
			crxf_pkg::OFS_IRQ_MASK: rd_mux = {14'h0000, irq_mask_q};
			default: rd_mux = 16'h0000;
		endcase
	end

	// read data valid only in the cycle after the strobe, zero otherwise
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			rdata_q <= crxf_pkg::RST_RDATA;
		end
		else if (i_rd)
		begin
			rdata_q <= rd_mux;
		end
		else
		begin
			rdata_q <= crxf_pkg::RST_RDATA;
		end
	end

	// low flag copy; costs a cycle of lag but keeps the output glitch free
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			flags_low_q <= crxf_pkg::RST_FLAGS;
		end
		else
		begin
			flags_low_q <= flags_low;
		end
	end

	// high flag copy, same lag as the low one
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			flags_high_q <= crxf_pkg::RST_FLAGS;
		end
		else
		begin
			flags_high_q <= flags_high;
		end
	end

	// outputs straight from flops
	assign o_rdata = rdata_q;
	assign o_rx_buffer_full_flag = {flags_high_q, flags_low_q};
	assign o_irq = irq_q;
endmodule
`default_nettype wire

/* core/crxf_pkg.sv */
// package for the receive buffer full flag block
package crxf_pkg;
	localparam int unsigned NUM_BUFFERS = 32;
	localparam int unsigned REG_WIDTH = 16;
	localparam int unsigned ADDR_WIDTH = 4;
	localparam int unsigned BUF_IDX_WIDTH = 5;
	// register offsets
	localparam logic [3:0] OFS_RX_BUFFER_FULL_LOW = 4'h0;
	localparam logic [3:0] OFS_RX_BUFFER_FULL_HIGH = 4'h1;
	localparam logic [3:0] OFS_IRQ_STATUS = 4'h2;
	localparam logic [3:0] OFS_IRQ_MASK = 4'h3;
	// reset values
	localparam logic [15:0] RST_FLAGS = 16'h0000;
	localparam logic [1:0] RST_IRQ = 2'h0;
	localparam logic [15:0] RST_RDATA = 16'h0000;
	localparam logic RST_IRQ_LINE = 1'h0;
	// interrupt status bit positions
	localparam int unsigned IRQ_BIT_STORED = 0;
	localparam int unsigned IRQ_BIT_OVERRUN = 1;
	localparam int unsigned IRQ_WIDTH = 2;
endpackage

/* core/crxf_flag_bank.sv */
// one 16-bit bank of sticky full flags
`timescale 1ns/10ps
`default_nettype none
module crxf_flag_bank
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// set and clear requests
	input wire logic [15:0] i_set,
	input wire logic i_clr_wr,
	input wire logic [15:0] i_clr_data,
	// flag state
	output logic [15:0] o_flags
);
	logic [15:0] flags_q;
	logic [15:0] flags_d;

	// write of 0 clears, 1 keeps; set beats clear
	always_comb
	begin
		flags_d = flags_q;
		if (i_clr_wr)
		begin
			flags_d = flags_q & i_clr_data;
		end
		flags_d = flags_d | i_set;
	end

	// no self clear: only software or reset lowers a flag
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			flags_q <= crxf_pkg::RST_FLAGS;
		end
		else
		begin
			flags_q <= flags_d;
		end
	end

	assign o_flags = flags_q;
endmodule
`default_nettype wire

/* verification/crxf_checker.sv */
// checker of the full flag block
`timescale 1ns/10ps
`default_nettype none
module crxf_checker
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// store path
	input wire logic i_store_valid,
	input wire logic [4:0] i_store_index,
	// register port
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [15:0] o_rdata,
	// flags and interrupt
	input wire logic [31:0] o_rx_buffer_full_flag,
	input wire logic o_irq
);
	logic [31:0] f;
	// short name; flags show two edges after a request
	assign f = o_rx_buffer_full_flag;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	chk_store_sets_flag: assert property (i_store_valid |=> ##1 f[$past(i_store_index, 2)])
		else $error("no set");
	chk_no_self_clear: assert property (!$past(i_wr, 2) |-> (~f & $past(f)) == 32'h0)
		else $error("dropped");
	chk_zero_clears: assert property (i_wr && i_addr == 4'h0 && !i_store_valid
		|=> ##1 (f[15:0] & ~$past(i_wdata, 2)) == 16'h0) else $error("kept");
	chk_low_read: assert property (i_rd && i_addr == 4'h0 |=> o_rdata == f[15:0])
		else $error("low");
	chk_high_read: assert property (i_rd && i_addr == 4'h1 |=> o_rdata == f[31:16])
		else $error("high");
	chk_set_wins: assert property (i_store_valid && i_wr && i_addr == {3'h0, i_store_index[4]}
		|=> ##1 f[$past(i_store_index, 2)]) else $error("lost");
	// main scenarios
	cover property (i_store_valid && i_wr);
	cover property (i_rd && i_addr == 4'h1);
	cover property ($fell(f[15]));
	cover property ($rose(o_irq));
endmodule
bind crxf_rx_buffer_full_flags crxf_checker crxf_checker_inst (.*);
`default_nettype wire

/* verification/crxf_rx_buffer_full_flags_tb_top.sv */
// bench of the full flag block
`timescale 1ns/10ps
`default_nettype none
module crxf_rx_buffer_full_flags_tb_top;
	logic i_clk = 1'h0, i_rst_b = 1'h0, i_store_valid = 1'h0, i_wr = 1'h0, i_rd = 1'h0, o_irq;
	logic [4:0] i_store_index = 5'h00;
	logic [3:0] i_addr = 4'h0;
	logic [15:0] i_wdata = 16'h0000, o_rdata;
	logic [31:0] o_rx_buffer_full_flag;
	int num_errors = 0, total_checks = 0, cycles = 0;
	crxf_rx_buffer_full_flags crxf_rx_buffer_full_flags_inst (.*);
	// clock
	initial
	begin
		forever #5 i_clk = ~i_clk;
	end
	// hang guard, the run needs about 80 cycles
	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles == 500)
		begin
			num_errors++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [16:0] e, g);
		total_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	// flag vector, looked at one edge after the internal flags move
	task automatic chk_flags(input logic [31:0] e);
		@(posedge i_clk);
		#1;
		total_checks++;
		if (o_rx_buffer_full_flag !== e)
		begin
			num_errors++;
			$display("wrong value %s exp %h got %h", "flags", e, o_rx_buffer_full_flag);
		end
	endtask
	// write; s lets the last store index ride along in the same cycle
	task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic s);
		@(posedge i_clk);
		i_wr <= 1'h1;
		i_addr <= a;
		i_wdata <= d;
		i_store_valid <= s;
		@(posedge i_clk);
		i_wr <= 1'h0;
		i_store_valid <= 1'h0;
	endtask
	task automatic st(input logic [4:0] n);
		@(posedge i_clk);
		i_store_valid <= 1'h1;
		i_store_index <= n;
		@(posedge i_clk);
		i_store_valid <= 1'h0;
	endtask
	// read data and interrupt are both looked at in the cycle after
	task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic q);
		@(posedge i_clk);
		i_rd <= 1'h1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'h0;
		#1;
		chk("read", {e, q}, {o_rdata, o_irq});
	endtask
	// reset, then the scenarios
	initial
	begin
		repeat (5) @(posedge i_clk);
		i_rst_b <= 1'h1;
		rd(4'h0, 16'h0000, 1'h0);
		rd(4'h1, 16'h0000, 1'h0);
		st(5'h00);
		st(5'h0F);
		st(5'h1F);
		st(5'h10);
		chk_flags(32'h80018001);
		rd(4'h0, 16'h8001, 1'h0);
		wr(4'h0, 16'h7FFF, 1'h0);
		repeat (20) @(posedge i_clk);
		chk_flags(32'h80010001);
		rd(4'h0, 16'h0001, 1'h0);
		rd(4'h1, 16'h8001, 1'h0);
		wr(4'h1, 16'h0000, 1'h1);
		chk_flags(32'h00010001);
		rd(4'h1, 16'h0001, 1'h0);
		// unmask both events, then clear them
		wr(4'h3, 16'h0003, 1'h0);
		rd(4'h2, 16'h0003, 1'h1);
		wr(4'h2, 16'h0003, 1'h0);
		rd(4'h2, 16'h0000, 1'h0);
		wr(4'h5, 16'hFFFF, 1'h0);
		rd(4'h5, 16'h0000, 1'h0);
		// second reset in mid-run: flags and mask must come back cleared
		@(posedge i_clk);
		i_rst_b <= 1'h0;
		repeat (5) @(posedge i_clk);
		i_rst_b <= 1'h1;
		chk_flags(32'h00000000);
		rd(4'h0, 16'h0000, 1'h0);
		rd(4'h1, 16'h0000, 1'h0);
		rd(4'h3, 16'h0000, 1'h0);
		final_report();
	end
endmodule
`default_nettype wire
